// File: hdl/sdc_regs.vh
// Constants for the SDRAM host controller: register map, fields, commands and timing
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// ----------------------------------------------------------------
// Register map (word addresses, byte address bits 4:2)
// ----------------------------------------------------------------
`define SDC_REG_CMD      3'h0
`define SDC_REG_ADDR     3'h1
`define SDC_REG_WDATA    3'h2
`define SDC_REG_STATUS   3'h3
`define SDC_REG_RDATA    3'h4
`define SDC_REG_MODE     3'h5

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define SDC_OP_NONE      3'h0
`define SDC_OP_OPEN      3'h1
`define SDC_OP_CLOSE     3'h2
`define SDC_OP_CLOSEALL  3'h3
`define SDC_OP_READ      3'h4
`define SDC_OP_WRITE     3'h5
`define SDC_OP_MODESET   3'h6
`define SDC_OP_REFRESH   3'h7

// Address register: [11:0] row/column, [13:12] bank
`define SDC_ADDR_BANK_LSB 12

// Status bits
`define SDC_ST_BUSY      0
`define SDC_ST_RVALID    1
`define SDC_ST_OPEN_LSB  4

// ----------------------------------------------------------------
// Pin encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define SDC_PIN_NOP      4'h7
`define SDC_PIN_DESEL    4'hf
`define SDC_PIN_ACT      4'h3
`define SDC_PIN_PRE      4'h2
`define SDC_PIN_READ     4'h5
`define SDC_PIN_WRITE    4'h4
`define SDC_PIN_MRS      4'h0
`define SDC_PIN_REF      4'h1

// Mode register fields and reset value
`define SDC_MODE_CL_LSB  4
`define SDC_MODE_RESET   12'h020

// ----------------------------------------------------------------
// Timing in ns, converted to 10 ns cycles, rounded up; tMRD is given in cycles
// ----------------------------------------------------------------
`define SDC_CLK_NS       10
`define SDC_T_RCD_NS     18
`define SDC_T_RAS_NS     42
`define SDC_T_RP_NS      18
`define SDC_T_RC_NS      60
`define SDC_T_RRD_NS     12
`define SDC_T_MRD_CYC    2
`define SDC_CYC(ns)      (((ns) + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
`define SDC_T_RAS_MAX_NS 100000

`endif

// File: hdl/sdc_timer.v
// Down counter that reports when a programmed wait has elapsed
`timescale 1ns/1ps
module sdc_timer #(
	parameter WIDTH = 16
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	output reg              done
);
	reg [WIDTH-1:0] count;

	always @(posedge clk) begin
		if (!reset_n) begin
			count <= {WIDTH{1'b0}};
			done  <= 1'b1;
		end else if (load) begin
			count <= value;
			done  <= (value == {WIDTH{1'b0}});
		end else if (count != {WIDTH{1'b0}}) begin
			count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			done  <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
endmodule

// File: hdl/sdc_host.v
// SDRAM host controller: Wishbone command registers driving the memory pins
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_host #(
	parameter RAS_MAX_CYC = `SDC_T_RAS_MAX_NS / `SDC_CLK_NS
) (
	input  wire        CLK_SYS,
	input  wire        RESET_N,
	// Wishbone classic slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [4:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// Memory pins
	output reg         MEM_CLOCK_GATE,
	output reg         MEM_CHIP_SELECT_N,
	output reg         MEM_ROW_STROBE_N,
	output reg         MEM_COLUMN_STROBE_N,
	output reg         MEM_WRITE_STROBE_N,
	output reg  [1:0]  MEM_BANK_SELECT,
	output reg  [11:0] MEM_ADDR,
	output reg         MEM_LOW_BYTE_MASK,
	output reg         MEM_HIGH_BYTE_MASK,
	input  wire [15:0] MEM_DQ_I,
	output reg  [15:0] MEM_DQ_O,
	output reg         MEM_DQ_OE,
	// Raised while the controller misses a bank's maximum open time
	output reg         RAS_OVERDUE
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_MASK  = 3'h1;
	localparam ST_ISSUE = 3'h2;
	localparam ST_WAIT  = 3'h3;
	localparam ST_READ  = 3'h4;

	localparam integer N_RCD = `SDC_CYC(`SDC_T_RCD_NS);
	localparam integer N_RAS = `SDC_CYC(`SDC_T_RAS_NS);
	localparam integer N_RP  = `SDC_CYC(`SDC_T_RP_NS);
	localparam integer N_RC  = `SDC_CYC(`SDC_T_RC_NS);
	localparam integer N_RRD = `SDC_CYC(`SDC_T_RRD_NS);
	localparam integer N_MRD = `SDC_T_MRD_CYC;
	localparam [15:0] C_RCD = N_RCD[15:0];
	localparam [15:0] C_RAS = N_RAS[15:0];
	localparam [15:0] C_RP  = N_RP[15:0];
	localparam [15:0] C_RC  = N_RC[15:0];
	localparam [15:0] C_RRD = N_RRD[15:0];
	localparam [15:0] C_MRD = N_MRD[15:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [2:0]  state;
	reg [2:0]  op;
	reg [13:0] addr;
	reg [15:0] wdata;
	reg [15:0] rdata;
	reg        rvalid;
	reg [11:0] mode;
	reg [3:0]  open_bank;
	reg [2:0]  wait_cnt;
	reg [2:0]  read_cnt;
	reg [31:0] ras_age [0:3];
	reg [3:0]  bank_load;
	reg        any_load;

	wire [3:0] rcd_ok;
	wire [3:0] ras_ok;
	wire [3:0] rc_ok;
	wire       rrd_ok;
	wire       issue_ok;
	wire [1:0] bank = addr[`SDC_ADDR_BANK_LSB+1:`SDC_ADDR_BANK_LSB];
	wire [2:0] latency = {1'b0, mode[`SDC_MODE_CL_LSB+1:`SDC_MODE_CL_LSB]};

	// ----------------------------------------------------------------
	// Per-bank timers and the shared open-to-open timer
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_bank
			sdc_timer #(.WIDTH(16)) u_rcd (
				.clk     (CLK_SYS),
				.reset_n (RESET_N),
				.load    (bank_load[g]),
				.value   (C_RCD),
				.done    (rcd_ok[g])
			);
			sdc_timer #(.WIDTH(16)) u_ras (
				.clk     (CLK_SYS),
				.reset_n (RESET_N),
				.load    (bank_load[g]),
				.value   (C_RAS),
				.done    (ras_ok[g])
			);
			sdc_timer #(.WIDTH(16)) u_rc (
				.clk     (CLK_SYS),
				.reset_n (RESET_N),
				.load    (bank_load[g]),
				.value   (C_RC),
				.done    (rc_ok[g])
			);
		end
	endgenerate

	sdc_timer #(.WIDTH(16)) u_rrd (
		.clk     (CLK_SYS),
		.reset_n (RESET_N),
		.load    (any_load),
		.value   (C_RRD),
		.done    (rrd_ok)
	);

	integer i;
	// Timers reload only when the open is issued; reloading while waiting would stall it
	always @* begin
		bank_load = 4'h0;
		any_load  = (state == ST_ISSUE) && (op == `SDC_OP_OPEN) && issue_ok;
		if (any_load) begin
			bank_load[bank] = 1'b1;
		end
	end

	// Commands wait here until the far-side timing holds
	function ready_for;
		input [2:0] o;
		input [1:0] b;
		input [3:0] rcd;
		input [3:0] ras;
		input [3:0] rc;
		input       rrd;
		begin
			case (o)
				`SDC_OP_OPEN:     ready_for = rc[b] && rrd;
				`SDC_OP_READ:     ready_for = rcd[b];
				`SDC_OP_WRITE:    ready_for = rcd[b];
				`SDC_OP_CLOSE:    ready_for = ras[b];
				`SDC_OP_CLOSEALL: ready_for = &ras;
				default:          ready_for = 1'b1;
			endcase
		end
	endfunction

	assign issue_ok = ready_for(op, bank, rcd_ok, ras_ok, rc_ok, rrd_ok);

	// ----------------------------------------------------------------
	// Wishbone slave: one wait state, ack for one cycle
	// ----------------------------------------------------------------
	wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire [2:0] reg_idx = WB_ADR_I[4:2];
	wire busy = (state != ST_IDLE) || (op != `SDC_OP_NONE);

	always @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= 32'h0000_0000;
			if (wb_req && !WB_WE_I) begin
				case (reg_idx)
					`SDC_REG_CMD:    WB_DAT_O <= {29'h0, op};
					`SDC_REG_ADDR:   WB_DAT_O <= {18'h0, addr};
					`SDC_REG_WDATA:  WB_DAT_O <= {16'h0, wdata};
					`SDC_REG_STATUS: WB_DAT_O <= {24'h0, open_bank, 2'h0, rvalid, busy};
					`SDC_REG_RDATA:  WB_DAT_O <= {16'h0, rdata};
					`SDC_REG_MODE:   WB_DAT_O <= {20'h0, mode};
					default:         WB_DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			state               <= ST_IDLE;
			op                  <= `SDC_OP_NONE;
			addr                <= 14'h0000;
			wdata               <= 16'h0000;
			rdata               <= 16'h0000;
			rvalid              <= 1'b0;
			mode                <= `SDC_MODE_RESET;
			open_bank           <= 4'h0;
			wait_cnt            <= 3'h0;
			read_cnt            <= 3'h0;
			MEM_CLOCK_GATE      <= 1'b1;
			{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_DESEL;
			MEM_BANK_SELECT     <= 2'h0;
			MEM_ADDR            <= 12'h000;
			MEM_LOW_BYTE_MASK   <= 1'b1;
			MEM_HIGH_BYTE_MASK  <= 1'b1;
			MEM_DQ_O            <= 16'h0000;
			MEM_DQ_OE           <= 1'b0;
		end else begin
			// Pins go back to NOP after every command cycle
			{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_NOP;
			MEM_DQ_OE <= 1'b0;
			if (wb_req && WB_WE_I && !busy && WB_SEL_I[0]) begin
				case (reg_idx)
					`SDC_REG_CMD: begin
						op     <= WB_DAT_I[2:0];
						rvalid <= (WB_DAT_I[2:0] == `SDC_OP_READ) ? 1'b0 : rvalid;
					end
					`SDC_REG_ADDR:  addr  <= WB_DAT_I[13:0];
					`SDC_REG_WDATA: wdata <= WB_DAT_I[15:0];
					default: ;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (op != `SDC_OP_NONE) begin
						// Write after a read: mask lands at least three clocks ahead
						if (op == `SDC_OP_WRITE) begin
							MEM_LOW_BYTE_MASK  <= 1'b1;
							MEM_HIGH_BYTE_MASK <= 1'b1;
							wait_cnt           <= 3'h2;
							state              <= ST_MASK;
						end else begin
							state <= ST_ISSUE;
						end
					end
				end
				ST_MASK: begin
					// Mask held two clocks also gives an idle bus cycle
					wait_cnt <= wait_cnt - 3'h1;
					if (wait_cnt == 3'h1) begin
						state <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (issue_ok) begin
						MEM_BANK_SELECT <= bank;
						MEM_ADDR        <= addr[11:0];
						state           <= ST_WAIT;
						wait_cnt        <= 3'h1;
						case (op)
							`SDC_OP_OPEN: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_ACT;
								open_bank[bank] <= 1'b1;
							end
							`SDC_OP_CLOSE: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_PRE;
								MEM_ADDR[10]    <= 1'b0;
								open_bank[bank] <= 1'b0;
								wait_cnt        <= C_RP[2:0];
							end
							`SDC_OP_CLOSEALL: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_PRE;
								MEM_ADDR[10] <= 1'b1;
								open_bank    <= 4'h0;
								wait_cnt     <= C_RP[2:0];
							end
							`SDC_OP_READ: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_READ;
								MEM_ADDR           <= {3'h0, addr[8:0]};
								MEM_LOW_BYTE_MASK  <= 1'b0;
								MEM_HIGH_BYTE_MASK <= 1'b0;
								read_cnt           <= latency;
								state              <= ST_READ;
							end
							`SDC_OP_WRITE: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_WRITE;
								MEM_ADDR           <= {3'h0, addr[8:0]};
								MEM_LOW_BYTE_MASK  <= 1'b0;
								MEM_HIGH_BYTE_MASK <= 1'b0;
								MEM_DQ_O           <= wdata;
								MEM_DQ_OE          <= 1'b1;
							end
							`SDC_OP_MODESET: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_MRS;
								MEM_BANK_SELECT <= 2'h0;
								mode            <= addr[11:0];
								wait_cnt        <= C_MRD[2:0];
							end
							default: begin
								{MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N} <= `SDC_PIN_REF;
								wait_cnt <= 3'h7;
							end
						endcase
					end
				end
				ST_READ: begin
					// Burst of one word; sampled latency edges after the command edge
					read_cnt <= read_cnt - 3'h1;
					if (read_cnt == 3'h0) begin
						rdata              <= MEM_DQ_I;
						rvalid             <= 1'b1;
						MEM_LOW_BYTE_MASK  <= 1'b1;
						MEM_HIGH_BYTE_MASK <= 1'b1;
						op                 <= `SDC_OP_NONE;
						state              <= ST_IDLE;
					end
				end
				ST_WAIT: begin
					wait_cnt <= wait_cnt - 3'h1;
					if (wait_cnt <= 3'h1) begin
						op    <= `SDC_OP_NONE;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Maximum open time watch; software must close the bank in time
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			RAS_OVERDUE <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				ras_age[i] <= 32'h0000_0000;
			end
		end else begin
			RAS_OVERDUE <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				if (!open_bank[i] || bank_load[i]) begin
					ras_age[i] <= 32'h0000_0000;
				end else if (ras_age[i] < RAS_MAX_CYC) begin
					ras_age[i] <= ras_age[i] + 32'h0000_0001;
				end else begin
					RAS_OVERDUE <= 1'b1;
				end
			end
		end
	end
endmodule

// File: testbench/sdc_mem_model.sv
// Behavioural four-bank SDRAM device answering the host controller
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_mem_model (
	input  wire         clk,
	input  wire         cke,
	input  wire  [3:0]  cmd,
	input  wire  [1:0]  ba,
	input  wire  [11:0] a,
	input  wire  [1:0]  dqm,
	input  wire  [15:0] din,
	input  wire         oe,
	output wire  [15:0] dq,
	output int          errors = 0
);
	localparam int RCD = `SDC_CYC(`SDC_T_RCD_NS);
	localparam int RAS = `SDC_CYC(`SDC_T_RAS_NS);
	localparam int RC = `SDC_CYC(`SDC_T_RC_NS);
	localparam int RRD = `SDC_CYC(`SDC_T_RRD_NS);
	logic [15:0] mem [int];
	logic [11:0] row [4];
	logic [3:0]  act = 4'h0;
	int          t_act [4] = '{-99, -99, -99, -99};
	int          t_any = -99;
	int          t = 0;
	int          k;
	logic [11:0] mode = `SDC_MODE_RESET;
	logic        cke_d = 1'b1;
	logic [1:0]  dqm1 = 2'b11;
	logic [1:0]  dqm2 = 2'b11;
	logic [16:0] pipe [4] = '{default: 17'h0};
	logic [16:0] nw;
	logic [15:0] last = 16'h0;
	int          left = 0;
	int          n = 0;
	logic [1:0]  rb = 2'h0;
	logic [8:0]  c0 = 9'h0;
	logic [8:0]  c;
	logic [8:0]  m;
	wire  [16:0] o = mode[4] ? pipe[2] : pipe[1];
	// Released lanes show the inverse of their last level, so stale data never passes for a read
	assign dq[15:8] = o[16] && !dqm2[1] ? o[15:8] : ~last[15:8];
	assign dq[7:0] = o[16] && !dqm2[0] ? o[7:0] : ~last[7:0];
	always @(posedge clk) begin
		nw = 17'h0;
		k = {ba, row[ba], a[8:0]};
		if (cke_d)
			case (cmd)
			`SDC_PIN_ACT: begin
				if (act[ba] || t - t_act[ba] < RC || t - t_any < RRD) errors++;
				act[ba] = 1'b1;
				row[ba] = a;
				t_act[ba] = t;
				t_any = t;
			end
			`SDC_PIN_PRE:
				for (int b = 0; b < 4; b++)
					if ((a[10] || b == ba) && act[b]) begin
						if (t - t_act[b] < RAS) errors++;
						if (b == rb) left = 0;
						act[b] = 1'b0;
					end
			`SDC_PIN_READ, `SDC_PIN_WRITE: begin
				if (!act[ba] || t - t_act[ba] < RCD) errors++;
				if (cmd == `SDC_PIN_READ) begin
					rb = ba;
					c0 = a[8:0];
					n = 0;
					left = mode[2:0] == 3'h7 ? -1 : 1 << mode[2:0];
				end else begin
					left = 0;
					if (dqm2 != 2'b11 || o[16]) errors++;
					if (oe) mem[k] = din;
				end
			end
			`SDC_PIN_MRS: mode <= a;
			default: ;
			endcase
		// Burst words; a low clock gate freezes the burst in place
		if (cke_d && left != 0) begin
			m = mode[2:0] == 3'h7 ? 9'h1ff : 9'((1 << mode[2:0]) - 1);
			c = mode[3] ? c0 ^ (9'(n) & m) : (c0 & ~m) | ((c0 + 9'(n)) & m);
			k = {rb, row[rb], c};
			nw = {1'b1, mem.exists(k) ? mem[k] : {rb, row[rb][5:0], c[7:0]}};
			n++;
			if (left > 0) left--;
		end
		pipe[0] <= nw;
		for (int i = 1; i < 4; i++) pipe[i] <= pipe[i - 1];
		dqm1 <= dqm;
		dqm2 <= dqm1;
		cke_d <= cke;
		last <= dq;
		t++;
	end
endmodule

// File: testbench/sdc_host_chk.sv
// Assertions on the host controller's bus handshake and memory command timing
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_host_chk #(
	parameter RAS_MAX_CYC = 10000
) (
	input wire        CLK_SYS,
	input wire        RESET_N,
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_ACK_O,
	input wire        MEM_CHIP_SELECT_N,
	input wire        MEM_ROW_STROBE_N,
	input wire        MEM_COLUMN_STROBE_N,
	input wire        MEM_WRITE_STROBE_N,
	input wire [1:0]  MEM_BANK_SELECT,
	input wire [11:0] MEM_ADDR,
	input wire        MEM_LOW_BYTE_MASK,
	input wire        MEM_HIGH_BYTE_MASK,
	input wire        MEM_DQ_OE,
	input wire        RAS_OVERDUE
);
	localparam int RAS = `SDC_CYC(`SDC_T_RAS_NS);
	localparam int RC = `SDC_CYC(`SDC_T_RC_NS);
	wire [3:0]  cmd = {MEM_CHIP_SELECT_N, MEM_ROW_STROBE_N, MEM_COLUMN_STROBE_N, MEM_WRITE_STROBE_N};
	wire        act = cmd == `SDC_PIN_ACT;
	wire        pre = cmd == `SDC_PIN_PRE;
	wire        acc = cmd == `SDC_PIN_READ || cmd == `SDC_PIN_WRITE;
	reg  [3:0]  open;
	reg  [15:0] age [0:3];
	reg  [3:0]  yg;
	reg  [3:0]  lt;
	integer     i;
	integer     j;
	wire [15:0] ag = age[MEM_BANK_SELECT];
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// ----------------------------------------------------------------
	// Per-bank open flag and cycles since opening, saturating
	// ----------------------------------------------------------------
	always @(posedge CLK_SYS)
		for (i = 0; i < 4; i = i + 1)
			if (!RESET_N) begin
				open[i] <= 1'b0;
				age[i] <= 16'hffff;
			end else if (act && MEM_BANK_SELECT == i) begin
				open[i] <= 1'b1;
				age[i] <= 16'h0;
			end else begin
				if (pre && (MEM_ADDR[10] || MEM_BANK_SELECT == i)) open[i] <= 1'b0;
				if (age[i] != 16'hffff) age[i] <= age[i] + 16'h1;
			end
	always @*
		for (j = 0; j < 4; j = j + 1) begin
			yg[j] = open[j] && age[j] < RAS - 1;
			lt[j] = open[j] && age[j] > RAS_MAX_CYC + 2;
		end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
	sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
	sequence s_quiet; !MEM_DQ_OE [*3]; endsequence
	property p_ack; s_req |=> s_pulse; endproperty
	property p_one; !cmd[3] && cmd != `SDC_PIN_NOP |=> cmd == `SDC_PIN_NOP; endproperty
	property p_rcd; act |=> !(acc && MEM_BANK_SELECT == $past(MEM_BANK_SELECT)); endproperty
	property p_rrd; act |=> !act; endproperty
	property p_rc; act |-> !open[MEM_BANK_SELECT] && ag >= RC - 1; endproperty
	property p_ras_min; pre |-> !(MEM_ADDR[10] ? |yg : yg[MEM_BANK_SELECT]); endproperty
	property p_ras_max; |lt |-> RAS_OVERDUE; endproperty
	property p_mask; cmd == `SDC_PIN_WRITE |-> $past(MEM_LOW_BYTE_MASK, 2) && $past(MEM_HIGH_BYTE_MASK, 2); endproperty
	property p_quiet; cmd == `SDC_PIN_READ |=> s_quiet; endproperty
	a_ack: assert property (p_ack) else $error("request not answered by a one-cycle ack");
	a_one: assert property (p_one) else $error("command held longer than one cycle");
	a_rcd: assert property (p_rcd) else $error("access too soon after opening its bank");
	a_rrd: assert property (p_rrd) else $error("two openings too close together");
	a_rc: assert property (p_rc) else $error("bank reopened while open or too soon");
	a_ras_min: assert property (p_ras_min) else $error("bank closed too soon after opening");
	a_ras_max: assert property (p_ras_max) else $error("bank open too long without overdue flag");
	a_mask: assert property (p_mask) else $error("write without masks raised two clocks ahead");
	a_quiet: assert property (p_quiet) else $error("data driven while read data may return");
endmodule
bind sdc_host sdc_host_chk #(.RAS_MAX_CYC(RAS_MAX_CYC)) sdc_host_chk_i (
	.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
	.MEM_CHIP_SELECT_N(MEM_CHIP_SELECT_N), .MEM_ROW_STROBE_N(MEM_ROW_STROBE_N),
	.MEM_COLUMN_STROBE_N(MEM_COLUMN_STROBE_N), .MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N),
	.MEM_BANK_SELECT(MEM_BANK_SELECT), .MEM_ADDR(MEM_ADDR), .MEM_LOW_BYTE_MASK(MEM_LOW_BYTE_MASK),
	.MEM_HIGH_BYTE_MASK(MEM_HIGH_BYTE_MASK), .MEM_DQ_OE(MEM_DQ_OE), .RAS_OVERDUE(RAS_OVERDUE));

// File: testbench/tb_top.sv
// Self-checking bench for the SDRAM host controller
`timescale 1ns/1ps
`include "sdc_regs.vh"
module tb_top;
	localparam RAS_MAX = 200;
	typedef struct packed {logic [2:0] o; logic [1:0] b; logic [11:0] a; logic [15:0] d, e; logic [3:0] open;} sdc_row_t;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [4:0]  wb_adr = 5'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [3:0]  wb_sel = 4'h0;
	logic [3:0]  sel_use = 4'hf;
	logic [31:0] q;
	wire  [31:0] wb_rdat, merr;
	wire         wb_ack, cke, cs_n, ras_n, cas_n, we_n, lmask, hmask, dq_oe, overdue;
	wire  [1:0]  ba;
	wire  [11:0] addr;
	wire  [15:0] dq_m, dq_o;
	wire  [15:0] dq_bus = dq_oe ? dq_o : dq_m;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;
	sdc_row_t    rows [15] = '{
		'{`SDC_OP_MODESET, 2'h0, 12'h020, 16'h0, 16'h0, 4'h0}, '{`SDC_OP_OPEN, 2'h0, 12'h005, 16'h0, 16'h0, 4'h1},
		'{`SDC_OP_OPEN, 2'h1, 12'h007, 16'h0, 16'h0, 4'h3}, '{`SDC_OP_WRITE, 2'h0, 12'h003, 16'ha5c3, 16'h0, 4'h3},
		'{`SDC_OP_READ, 2'h0, 12'h003, 16'h0, 16'ha5c3, 4'h3}, '{`SDC_OP_READ, 2'h1, 12'h1ff, 16'h0, 16'h47ff, 4'h3},
		'{`SDC_OP_WRITE, 2'h1, 12'h000, 16'h1234, 16'h0, 4'h3}, '{`SDC_OP_READ, 2'h1, 12'h000, 16'h0, 16'h1234, 4'h3},
		'{`SDC_OP_CLOSE, 2'h0, 12'h000, 16'h0, 16'h0, 4'h2}, '{`SDC_OP_CLOSEALL, 2'h0, 12'h000, 16'h0, 16'h0, 4'h0},
		'{`SDC_OP_MODESET, 2'h0, 12'h030, 16'h0, 16'h0, 4'h0}, '{`SDC_OP_OPEN, 2'h2, 12'habc, 16'h0, 16'h0, 4'h4},
		'{`SDC_OP_READ, 2'h2, 12'h010, 16'h0, 16'hbc10, 4'h4}, '{`SDC_OP_CLOSEALL, 2'h1, 12'h000, 16'h0, 16'h0, 4'h0},
		'{`SDC_OP_REFRESH, 2'h0, 12'h000, 16'h0, 16'h0, 4'h0}};
	always #5 clk_sys = ~clk_sys;
	sdc_host #(.RAS_MAX_CYC(RAS_MAX)) sdc_host_i (
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
		.WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
		.MEM_CLOCK_GATE(cke), .MEM_CHIP_SELECT_N(cs_n), .MEM_ROW_STROBE_N(ras_n), .MEM_COLUMN_STROBE_N(cas_n),
		.MEM_WRITE_STROBE_N(we_n), .MEM_BANK_SELECT(ba), .MEM_ADDR(addr), .MEM_LOW_BYTE_MASK(lmask),
		.MEM_HIGH_BYTE_MASK(hmask), .MEM_DQ_I(dq_bus), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .RAS_OVERDUE(overdue));
	sdc_mem_model sdc_mem_model_i (.clk(clk_sys), .cke(cke), .cmd({cs_n, ras_n, cas_n, we_n}), .ba(ba), .a(addr),
		.dqm({hmask, lmask}), .din(dq_bus), .oe(dq_oe), .dq(dq_m), .errors(merr));
	task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [2:0] r, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {r, 2'b00};
		wb_wdat <= d;
		wb_sel <= sel_use;
		do @(posedge clk_sys); while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
	endtask
	task automatic op(input logic [2:0] o, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
		wb(1'b1, `SDC_REG_ADDR, {18'h0, b, a});
		wb(1'b1, `SDC_REG_WDATA, {16'h0, d});
		wb(1'b1, `SDC_REG_CMD, {29'h0, o});
		do wb(1'b0, `SDC_REG_STATUS, 32'h0); while (q[`SDC_ST_BUSY] !== 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		check("pins in reset", 32'hbf, 32'({cke, dq_oe, lmask, hmask, cs_n, ras_n, cas_n, we_n}));
		reset_n <= 1'b1;
		wb(1'b0, `SDC_REG_MODE, 32'h0);
		check("mode after reset", 32'h020, q);
		wb(1'b0, 3'h7, 32'h0);
		check("unmapped read", 32'h0, q);
		foreach (rows[i]) begin
			op(rows[i].o, rows[i].b, rows[i].a, rows[i].d);
			check("open banks", 32'(rows[i].open), 32'(q[7:4]));
			if (rows[i].o == `SDC_OP_READ) begin
				check("read valid", 32'h1, 32'(q[`SDC_ST_RVALID]));
				wb(1'b0, `SDC_REG_RDATA, 32'h0);
				check("read word", 32'(rows[i].e), 32'(q[15:0]));
			end
			if (rows[i].o == `SDC_OP_MODESET) begin
				wb(1'b0, `SDC_REG_MODE, 32'h0);
				check("mode copy", 32'(rows[i].a), q);
			end
		end
		op(`SDC_OP_OPEN, 2'h3, 12'h001, 16'h0);
		repeat (RAS_MAX + 10) @(posedge clk_sys);
		check("overdue flag", 32'h1, 32'(overdue));
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("pins in second reset", 32'hbf, 32'({cke, dq_oe, lmask, hmask, cs_n, ras_n, cas_n, we_n}));
		check("overdue in reset", 32'h0, 32'(overdue));
		reset_n <= 1'b1;
		op(`SDC_OP_CLOSEALL, 2'h0, 12'h000, 16'h0);
		check("open banks after reset", 32'h0, 32'(q[7:4]));
		check("device timing faults", 32'h0, merr);
		sel_use = 4'he;
		wb(1'b1, `SDC_REG_ADDR, 32'h3fff);
		sel_use = 4'hf;
		wb(1'b0, `SDC_REG_ADDR, 32'h0);
		check("address after masked write", 32'h0, q);
		tally_and_finish();
	end
endmodule
